// ==== gpx_gpio.sv ====
// Pin-sharing general purpose I/O block with APB register access
//
// The implementer's own choice: the APB slave port.
`timescale 1ns/100ps
`default_nettype none
`include "gpx_defines.svh"

// Notes on behaviour
// - Twenty-seven pins: port0 bits 6..0, port1 and port4 eight, port5 bits 3..0.
// - Direction bit 0 makes the pin an input, 1 an output.
// - Direction bits clear at reset; missing bit positions read zero, do nothing.
// - Pull-up bit 1 enables, 0 disables the pin pull-up; clears at reset.
// - Pull-up acts only on input pins, never on a driving pin.
// - Port0 bits 0 and 1 feed external interrupts when their enables are set.
// - Port0 bits 0..3 clock timers 0,1,2,wide when select and enable set.
// - Port0 bit 2 is UART receive, bit 3 UART transmit, when enabled.
// - Port0 bit 4 becomes reset input when the reset pin option says so.
// - Port0 bits 5,6 are oscillator pins for crystal; RC takes only bit 6.
// - Port1 bits 0,1 are debug clock and data in debug mode.
// - Port1 bits 2,3 are SDA and SCL when master serial is enabled.
// - Port4 bit n is analog input n when converter enable and global channel bits are set and select equals n.
// - Port5 bits 0..3 are analog inputs 8..11 for selects 8..11.
// - Port5 bits 1..3 drive PWM 0..2 with timer0 and output enable set.
module gpx_gpio (
	input  wire logic                pclk,
	input  wire logic                presetn,
	input  wire logic                psel,
	input  wire logic                penable,
	input  wire logic                pwrite,
	input  wire logic [11:0]         paddr,
	input  wire logic [31:0]         pwdata,
	input  wire logic [3:0]          pstrb,
	output logic      [31:0]         prdata,
	output logic                     pready,
	output logic                     pslverr,
	input  wire logic [26:0]         pad_in,
	output gpx_pkg::gpx_pad_s        pad,
	input  wire gpx_pkg::gpx_periph_s periph,
	output gpx_pkg::gpx_func_s       func,
	input  wire logic                reset_pin_option,
	input  wire gpx_pkg::gpx_osc_e   osc_option,
	input  wire logic                debug_mode
);
	import gpx_pkg::*;

	// ---------------------------------------------------------------
	// Register file
	// ---------------------------------------------------------------
	logic [7:0]  direction [4];
	logic [7:0]  pullup_bits [4];
	logic [7:0]  data_out  [4];
	logic [7:0]  timer_ctrl;
	logic [7:0]  func_ctrl;
	logic [7:0]  converter_ctrl;
	logic [7:0]  pwm_ctrl;
	logic        reset_pin_q;
	gpx_osc_e    osc_q;

	logic [7:0]  idx;
	logic        addr_ok;
	logic        wr_en;
	logic [7:0]  wbyte;
	logic [7:0]  next_rdata;
	logic        next_err;

	assign idx     = paddr[9:2];
	assign addr_ok = (paddr[1:0] == 2'h0) && (paddr[11:10] == 2'h0);
	assign wr_en   = psel && penable && pready && pwrite && pstrb[0] && !next_err;
	assign wbyte   = pwdata[7:0];

	// Flat views of the per-port registers
	logic [26:0] dir_flat;
	logic [26:0] pu_flat;
	logic [26:0] dout_flat;

	assign dir_flat  = {direction[3][3:0], direction[2], direction[1], direction[0][6:0]};
	assign pu_flat   = {pullup_bits[3][3:0], pullup_bits[2], pullup_bits[1], pullup_bits[0][6:0]};
	assign dout_flat = {data_out[3][3:0], data_out[2], data_out[1], data_out[0][6:0]};

	// Read decode and unmapped answer
	always_comb begin
		next_rdata = 8'h00;
		next_err   = 1'b0;
		if (!addr_ok) begin
			next_err = 1'b1;
		end else begin
			unique case (idx)
				`GPX_IDX_PORT0_DIRECTION:     next_rdata = direction[0];
				`GPX_IDX_PORT1_DIRECTION:     next_rdata = direction[1];
				`GPX_IDX_PORT4_DIRECTION:     next_rdata = direction[2];
				`GPX_IDX_PORT5_DIRECTION:     next_rdata = direction[3];
				`GPX_IDX_PORT0_PULLUP_ENABLE: next_rdata = pullup_bits[0];
				`GPX_IDX_PORT1_PULLUP_ENABLE: next_rdata = pullup_bits[1];
				`GPX_IDX_PORT4_PULLUP_ENABLE: next_rdata = pullup_bits[2];
				`GPX_IDX_PORT5_PULLUP_ENABLE: next_rdata = pullup_bits[3];
				`GPX_IDX_TIMER_PIN_CTRL:      next_rdata = timer_ctrl;
				`GPX_IDX_FUNC_PIN_CTRL:       next_rdata = func_ctrl;
				`GPX_IDX_CONVERTER_CTRL:      next_rdata = converter_ctrl;
				`GPX_IDX_PWM_PIN_CTRL:        next_rdata = pwm_ctrl;
				`GPX_IDX_PORT0_DATA_OUT:      next_rdata = data_out[0];
				`GPX_IDX_PORT1_DATA_OUT:      next_rdata = data_out[1];
				`GPX_IDX_PORT4_DATA_OUT:      next_rdata = data_out[2];
				`GPX_IDX_PORT5_DATA_OUT:      next_rdata = data_out[3];
				`GPX_IDX_PORT0_PIN_LEVEL:     next_rdata = {1'b0, pad_in[6:0]};
				`GPX_IDX_PORT1_PIN_LEVEL:     next_rdata = pad_in[14:7];
				`GPX_IDX_PORT4_PIN_LEVEL:     next_rdata = pad_in[22:15];
				`GPX_IDX_PORT5_PIN_LEVEL:     next_rdata = {4'h0, pad_in[26:23]};
				default:                      next_err   = 1'b1;
			endcase
		end
	end

	// APB answer: ready in the first access cycle, data captured in setup
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready  <= 1'b0;
			prdata  <= 32'h0000_0000;
			pslverr <= 1'b0;
		end else begin
			pready  <= psel && !penable;
			pslverr <= psel && !penable && next_err;
			if (psel && !penable && !pwrite) begin
				prdata <= {24'h00_0000, next_rdata};
			end
		end
	end

	// Direction and pull-up bits, masked to the implemented pins
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			for (int p = 0; p < 4; p++) begin
				direction[p] <= `GPX_RESET_VALUE;
				pullup_bits[p] <= `GPX_RESET_VALUE;
			end
		end else if (wr_en) begin
			unique case (idx)
				`GPX_IDX_PORT0_DIRECTION:     direction[0] <= wbyte & `GPX_MASK_PORT0;
				`GPX_IDX_PORT1_DIRECTION:     direction[1] <= wbyte & `GPX_MASK_PORT1;
				`GPX_IDX_PORT4_DIRECTION:     direction[2] <= wbyte & `GPX_MASK_PORT4;
				`GPX_IDX_PORT5_DIRECTION:     direction[3] <= wbyte & `GPX_MASK_PORT5;
				`GPX_IDX_PORT0_PULLUP_ENABLE: pullup_bits[0] <= wbyte & `GPX_MASK_PORT0;
				`GPX_IDX_PORT1_PULLUP_ENABLE: pullup_bits[1] <= wbyte & `GPX_MASK_PORT1;
				`GPX_IDX_PORT4_PULLUP_ENABLE: pullup_bits[2] <= wbyte & `GPX_MASK_PORT4;
				`GPX_IDX_PORT5_PULLUP_ENABLE: pullup_bits[3] <= wbyte & `GPX_MASK_PORT5;
				default: ;
			endcase
		end
	end

	// Output data latches and alternate function controls
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			for (int p = 0; p < 4; p++) begin
				data_out[p] <= `GPX_RESET_VALUE;
			end
			timer_ctrl     <= `GPX_RESET_VALUE;
			func_ctrl      <= `GPX_RESET_VALUE;
			converter_ctrl <= `GPX_RESET_VALUE;
			pwm_ctrl       <= `GPX_RESET_VALUE;
		end else if (wr_en) begin
			unique case (idx)
				`GPX_IDX_PORT0_DATA_OUT:  data_out[0]    <= wbyte & `GPX_MASK_PORT0;
				`GPX_IDX_PORT1_DATA_OUT:  data_out[1]    <= wbyte & `GPX_MASK_PORT1;
				`GPX_IDX_PORT4_DATA_OUT:  data_out[2]    <= wbyte & `GPX_MASK_PORT4;
				`GPX_IDX_PORT5_DATA_OUT:  data_out[3]    <= wbyte & `GPX_MASK_PORT5;
				`GPX_IDX_TIMER_PIN_CTRL:  timer_ctrl     <= wbyte;
				`GPX_IDX_FUNC_PIN_CTRL:   func_ctrl      <= wbyte & 8'h3f;
				`GPX_IDX_CONVERTER_CTRL:  converter_ctrl <= wbyte & 8'h9f;
				`GPX_IDX_PWM_PIN_CTRL:    pwm_ctrl       <= wbyte & 8'h07;
				default: ;
			endcase
		end
	end

	// Build-time options are sampled after reset release
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			reset_pin_q <= 1'b0;
			osc_q       <= GPX_OSC_NONE;
		end else begin
			reset_pin_q <= reset_pin_option;
			osc_q       <= osc_option;
		end
	end

	// ---------------------------------------------------------------
	// Alternate function ownership
	// ---------------------------------------------------------------
	logic [3:0]  tmr_pin_on;
	logic        adc_on;
	logic [3:0]  channel_select;
	logic [26:0] alt_own;
	logic [26:0] alt_oe;
	logic [26:0] alt_out;
	logic [26:0] ana;

	assign tmr_pin_on = timer_ctrl[`GPX_FLD_TIMER_CKS_LSB +: 4] & timer_ctrl[`GPX_FLD_TIMER_ENB_LSB +: 4];
	assign channel_select = converter_ctrl[`GPX_FLD_CHANNEL_LSB +: 4];
	assign adc_on     = converter_ctrl[`GPX_FLD_CONVERTER_EN] && converter_ctrl[`GPX_FLD_GLOBAL_CHANNEL];

	always_comb begin
		alt_own = 27'h0;
		alt_oe  = 27'h0;
		alt_out = 27'h0;
		// Port 0 digital inputs, UART transmit, reset pin and oscillator pins
		alt_own[0] = func_ctrl[`GPX_FLD_EXT_IRQ0_EN] || tmr_pin_on[0];
		alt_own[1] = func_ctrl[`GPX_FLD_EXT_IRQ1_EN] || tmr_pin_on[1];
		alt_own[2] = func_ctrl[`GPX_FLD_UART_RX_EN] || tmr_pin_on[2];
		alt_own[3] = func_ctrl[`GPX_FLD_UART_TX_EN] || tmr_pin_on[3];
		alt_oe[3]  = func_ctrl[`GPX_FLD_UART_TX_EN];
		alt_out[3] = periph.uart_transmit_pin;
		alt_own[4] = reset_pin_q;
		alt_own[5] = (osc_q == GPX_OSC_XTAL);
		alt_own[6] = (osc_q == GPX_OSC_XTAL) || (osc_q == GPX_OSC_RC);
		// Port 1 debug lines
		alt_own[`GPX_P1_BASE + 0] = debug_mode;
		alt_own[`GPX_P1_BASE + 1] = debug_mode;
		alt_oe[`GPX_P1_BASE + 1]  = debug_mode && periph.debug_data_oe;
		alt_out[`GPX_P1_BASE + 1] = periph.debug_data_out;
		// Port 1 master serial port
		alt_own[`GPX_P1_BASE + 2] = func_ctrl[`GPX_FLD_MASTER_SER_EN];
		alt_own[`GPX_P1_BASE + 3] = func_ctrl[`GPX_FLD_MASTER_SER_EN];
		alt_oe[`GPX_P1_BASE + 2]  = func_ctrl[`GPX_FLD_MASTER_SER_EN] && periph.sda_oe;
		alt_oe[`GPX_P1_BASE + 3]  = func_ctrl[`GPX_FLD_MASTER_SER_EN] && periph.scl_oe;
		alt_out[`GPX_P1_BASE + 2] = periph.sda_out;
		alt_out[`GPX_P1_BASE + 3] = periph.scl_out;
		// Port 1 serial interface
		for (int k = 4; k < 8; k++) begin
			alt_own[`GPX_P1_BASE + k] = func_ctrl[`GPX_FLD_SERIAL_IF_EN];
		end
		alt_oe[`GPX_P1_BASE + 4]  = func_ctrl[`GPX_FLD_SERIAL_IF_EN];
		alt_out[`GPX_P1_BASE + 4] = periph.serial_data_out;
		alt_oe[`GPX_P1_BASE + 6]  = func_ctrl[`GPX_FLD_SERIAL_IF_EN] && periph.sck_oe;
		alt_out[`GPX_P1_BASE + 6] = periph.sck_out;
		alt_oe[`GPX_P1_BASE + 7]  = func_ctrl[`GPX_FLD_SERIAL_IF_EN] && periph.serial_chip_select_oe;
		alt_out[`GPX_P1_BASE + 7] = periph.serial_chip_select_out;
		// Port 5 PWM outputs
		for (int k = 0; k < 3; k++) begin
			alt_own[`GPX_P5_BASE + 1 + k] = timer_ctrl[`GPX_FLD_TIMER_ENB_LSB] && pwm_ctrl[k];
			alt_oe[`GPX_P5_BASE + 1 + k]  = timer_ctrl[`GPX_FLD_TIMER_ENB_LSB] && pwm_ctrl[k];
			alt_out[`GPX_P5_BASE + 1 + k] = periph.pwm[k];
		end
	end

	// Analog input selection, one channel at most; oscillator pins are analog too
	assign ana[4:0] = 5'h00;
	assign ana[5]   = alt_own[5];
	assign ana[6]   = alt_own[6];
	assign ana[14:7] = 8'h00;

	genvar ch;
	generate
		for (ch = 0; ch < `GPX_NUM_ANALOG; ch++) begin : g_analog
			assign ana[`GPX_P4_BASE + ch] = adc_on && (channel_select == 4'(ch));
		end
	endgenerate

	// ---------------------------------------------------------------
	// Per-pin resolution
	// ---------------------------------------------------------------
	logic [26:0] next_out;
	logic [26:0] next_oe;
	logic [26:0] next_pu;
	logic [26:0] own_any;

	genvar i;
	generate
		for (i = 0; i < `GPX_NUM_PINS; i++) begin : g_pin
			assign own_any[i]  = alt_own[i] || ana[i];
			assign next_oe[i]  = ana[i] ? 1'b0 : (alt_own[i] ? alt_oe[i] : dir_flat[i]);
			assign next_out[i] = alt_own[i] ? alt_out[i] : dout_flat[i];
			assign next_pu[i]  = pu_flat[i] && !next_oe[i] && !ana[i];
		end
	endgenerate

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pad <= '0;
		end else begin
			pad.out    <= next_out;
			pad.oe     <= next_oe;
			pad.pull_up <= next_pu;
			pad.analog <= ana;
		end
	end

	// Pin levels to the peripherals, gated by their enables
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			func             <= '0;
			func.ext_reset_n <= 1'b1;
		end else begin
			func.ext_irq0_input        <= func_ctrl[`GPX_FLD_EXT_IRQ0_EN] && pad_in[0];
			func.ext_irq1_input        <= func_ctrl[`GPX_FLD_EXT_IRQ1_EN] && pad_in[1];
			func.timer_clock           <= tmr_pin_on & pad_in[3:0];
			func.uart_receive_pin      <= !func_ctrl[`GPX_FLD_UART_RX_EN] || pad_in[2];
			func.ext_reset_n           <= !reset_pin_q || pad_in[4];
			func.osc_input_pin         <= alt_own[6] && pad_in[6];
			func.debug_clock_pin       <= debug_mode && pad_in[`GPX_P1_BASE + 0];
			func.debug_data_in         <= debug_mode && pad_in[`GPX_P1_BASE + 1];
			func.sda_in                <= !func_ctrl[`GPX_FLD_MASTER_SER_EN] || pad_in[`GPX_P1_BASE + 2];
			func.scl_in                <= !func_ctrl[`GPX_FLD_MASTER_SER_EN] || pad_in[`GPX_P1_BASE + 3];
			func.serial_data_in        <= func_ctrl[`GPX_FLD_SERIAL_IF_EN] && pad_in[`GPX_P1_BASE + 5];
			func.sck_in                <= func_ctrl[`GPX_FLD_SERIAL_IF_EN] && pad_in[`GPX_P1_BASE + 6];
			func.serial_chip_select_in <= !func_ctrl[`GPX_FLD_SERIAL_IF_EN] || pad_in[`GPX_P1_BASE + 7];
		end
	end

	// ---------------------------------------------------------------
	// Assertions
	// ---------------------------------------------------------------
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	a_pin_count_map: assert property ($bits(dir_flat) == 27 && direction[0][7] == 1'b0)
		else $error("Pin map is not 27 pins wide");

	a_dir_reset_clear: assert property ($rose(presetn) |-> dir_flat == 27'h0 && pu_flat == 27'h0)
		else $error("Direction or pull-up not clear after reset");

	a_unimpl_zero: assert property (direction[3][7:4] == 4'h0 && pullup_bits[0][7] == 1'b0)
		else $error("Unimplemented direction bit holds a value");

	a_dir_sets_oe: assert property ((pad.oe & ~$past(own_any)) == ($past(dir_flat) & ~$past(own_any)))
		else $error("Pin enable does not follow direction bit");

	a_pullup_input_only: assert property ((pad.pull_up & pad.oe) == 27'h0 &&
		(pad.pull_up & ~$past(pu_flat)) == 27'h0)
		else $error("Pull-up active on a driving pin");

	a_pullup_applied: assert property (!$past(next_oe[8]) && $past(pu_flat[8]) && !$past(own_any[8]) |-> pad.pull_up[8])
		else $error("Enabled pull-up not applied on input pin");

	a_alt_overrides: assert property ((pad.oe & $past(alt_own) & ~$past(ana)) ==
		($past(alt_oe) & $past(alt_own) & ~$past(ana)))
		else $error("Alternate function does not own the pin");

	a_analog_one_hot: assert property ($onehot0(pad.analog[26:15]) && ((pad.analog[26:15] & pad.oe[26:15]) == 12'h0))
		else $error("More than one analog input or analog pin driven");

	a_chan9_select: assert property (adc_on && channel_select == 4'h9 |=>
		pad.analog[24] && !pad.oe[24] && !pad.pull_up[24])
		else $error("Channel nine did not take port five bit one");

	a_pwm_drive: assert property (timer_ctrl[4] && pwm_ctrl[0] && !ana[24] |=> pad.oe[24] && pad.out[24] == $past(periph.pwm[0]))
		else $error("PWM channel zero not on its pin");

	a_uart_rx_path: assert property (func_ctrl[2] |=> func.uart_receive_pin == $past(pad_in[2]))
		else $error("UART receive does not follow its pin");

	a_irq0_path: assert property (func_ctrl[0] && pad_in[0] |=> func.ext_irq0_input)
		else $error("External interrupt zero lost");

	a_reset_pin: assert property (reset_pin_q |=> !pad.oe[4] && func.ext_reset_n == $past(pad_in[4]))
		else $error("Reset pin driven or not followed");

	a_apb_ready: assert property (psel && !penable |=> pready ##1 !pready)
		else $error("APB answer not one cycle after setup");

	c_analog_used: cover property (adc_on && channel_select == 4'h3 ##1 pad.analog[18]);
	c_uart_tx_pin: cover property (func_ctrl[3] ##1 pad.oe[3]);
	c_pullup_input: cover property (pad.pull_up[20] ##1 pad.oe[20]);

endmodule : gpx_gpio
`default_nettype wire

// ==== gpx_defines.svh ====
// Register indices, field positions, reset values and pin map of the pin-sharing I/O block
`ifndef GPX_DEFINES_SVH
`define GPX_DEFINES_SVH

// ---------------------------------------------------------------
// Register indices (byte address is four times the index)
// ---------------------------------------------------------------
`define GPX_IDX_PORT0_DIRECTION      8'ha0
`define GPX_IDX_PORT1_DIRECTION      8'ha1
`define GPX_IDX_PORT4_DIRECTION      8'ha4
`define GPX_IDX_PORT5_DIRECTION      8'ha5
`define GPX_IDX_PORT0_PULLUP_ENABLE  8'hac
`define GPX_IDX_PORT1_PULLUP_ENABLE  8'had
`define GPX_IDX_PORT4_PULLUP_ENABLE  8'hb0
`define GPX_IDX_PORT5_PULLUP_ENABLE  8'hb1
`define GPX_IDX_TIMER_PIN_CTRL       8'hc0
`define GPX_IDX_FUNC_PIN_CTRL        8'hc1
`define GPX_IDX_CONVERTER_CTRL       8'hc2
`define GPX_IDX_PWM_PIN_CTRL         8'hc3
`define GPX_IDX_PORT0_DATA_OUT       8'hd0
`define GPX_IDX_PORT1_DATA_OUT       8'hd1
`define GPX_IDX_PORT4_DATA_OUT       8'hd2
`define GPX_IDX_PORT5_DATA_OUT       8'hd3
`define GPX_IDX_PORT0_PIN_LEVEL      8'hd4
`define GPX_IDX_PORT1_PIN_LEVEL      8'hd5
`define GPX_IDX_PORT4_PIN_LEVEL      8'hd6
`define GPX_IDX_PORT5_PIN_LEVEL      8'hd7

// ---------------------------------------------------------------
// Implemented bits per port and reset value
// ---------------------------------------------------------------
`define GPX_MASK_PORT0  8'h7f
`define GPX_MASK_PORT1  8'hff
`define GPX_MASK_PORT4  8'hff
`define GPX_MASK_PORT5  8'h0f
`define GPX_RESET_VALUE 8'h00

// ---------------------------------------------------------------
// Field positions
// ---------------------------------------------------------------
`define GPX_FLD_TIMER_CKS_LSB   0
`define GPX_FLD_TIMER_ENB_LSB   4
`define GPX_FLD_EXT_IRQ0_EN     0
`define GPX_FLD_EXT_IRQ1_EN     1
`define GPX_FLD_UART_RX_EN      2
`define GPX_FLD_UART_TX_EN      3
`define GPX_FLD_MASTER_SER_EN   4
`define GPX_FLD_SERIAL_IF_EN    5
`define GPX_FLD_CHANNEL_LSB     0
`define GPX_FLD_GLOBAL_CHANNEL  4
`define GPX_FLD_CONVERTER_EN    7

// ---------------------------------------------------------------
// Flat pin map: port 0 at 0, port 1 at 7, port 4 at 15, port 5 at 23
// ---------------------------------------------------------------
`define GPX_NUM_PINS    27
`define GPX_P1_BASE     7
`define GPX_P4_BASE     15
`define GPX_P5_BASE     23
`define GPX_NUM_ANALOG  12

`endif

// ==== gpx_pkg.sv ====
// Types shared by the pin-sharing I/O block and its surroundings
package gpx_pkg;

	// Build-time oscillator option
	typedef enum logic [2:0] {
		GPX_OSC_NONE = 3'b001,
		GPX_OSC_RC   = 3'b010,
		GPX_OSC_XTAL = 3'b100
	} gpx_osc_e;

	// Pad controls, one bit per pin in flat order
	typedef struct packed {
		logic [26:0] out;
		logic [26:0] oe;
		logic [26:0] pull_up;
		logic [26:0] analog;
	} gpx_pad_s;

	// Signals from the peripherals toward the pins
	typedef struct packed {
		logic       uart_transmit_pin;
		logic       sda_out;
		logic       sda_oe;
		logic       scl_out;
		logic       scl_oe;
		logic       serial_data_out;
		logic       sck_out;
		logic       sck_oe;
		logic       serial_chip_select_out;
		logic       serial_chip_select_oe;
		logic       debug_data_out;
		logic       debug_data_oe;
		logic [2:0] pwm;
	} gpx_periph_s;

	// Pin levels handed to the peripherals
	typedef struct packed {
		logic       ext_irq0_input;
		logic       ext_irq1_input;
		logic [3:0] timer_clock;
		logic       uart_receive_pin;
		logic       sda_in;
		logic       scl_in;
		logic       serial_data_in;
		logic       sck_in;
		logic       serial_chip_select_in;
		logic       debug_clock_pin;
		logic       debug_data_in;
		logic       osc_input_pin;
		logic       ext_reset_n;
	} gpx_func_s;

endpackage : gpx_pkg

// ==== gpx_pins_model.sv ====
// Model of the circuits outside the pins: pin drivers, pull-ups and an external level
`timescale 1ns/100ps
`default_nettype none
module gpx_pins_model (
	input  wire logic [26:0] oe,
	input  wire logic [26:0] out,
	input  wire logic [26:0] pull_up,
	input  wire logic [26:0] ext,
	output logic      [26:0] level
);
	// Driven pins show the driver, released pins the pull-up or the outside level
	always_comb begin
		for (int i = 0; i < 27; i++) begin
			level[i] = oe[i] ? out[i] : (pull_up[i] ? 1'b1 : ext[i]);
		end
	end
endmodule : gpx_pins_model
`default_nettype wire

// ==== gpx_tb.sv ====
// Self-checking testbench of the pin-sharing I/O block
`timescale 1ns/100ps
`default_nettype none
`define CHK(a, e) begin tests_run++; if ((a) !== (e)) begin err_count++; \
	$display("ERROR t=%0t got=%h exp=%h", $time, (a), (e)); end end
module testbench;
	import gpx_pkg::*;
	typedef struct {logic [7:0] idx; logic [7:0] wd; logic [7:0] exp;} gpx_row_s;
	logic        pclk    = 1'b0;
	logic        presetn = 1'b0;
	logic        psel    = 1'b0;
	logic        penable = 1'b0;
	logic        pwrite  = 1'b0;
	logic [11:0] paddr   = 12'h000;
	logic [31:0] pwdata  = 32'h0;
	logic [3:0]  pstrb   = 4'hf;
	logic [31:0] prdata;
	logic        pready;
	logic        pslverr;
	logic [26:0] pad_in;
	logic [26:0] ext     = 27'h0;
	logic [26:0] exp;
	gpx_pad_s    pad;
	gpx_periph_s periph  = '0;
	gpx_func_s   func;
	logic        rst_opt = 1'b0;
	logic        dbg     = 1'b0;
	gpx_osc_e    osc     = GPX_OSC_NONE;
	logic [31:0] rd;
	logic        slv;
	int          err_count = 0;
	int          tests_run = 0;
	gpx_row_s    rows [8] = '{'{8'ha0, 8'hff, 8'h7f}, '{8'ha1, 8'ha5, 8'ha5}, '{8'ha4, 8'h3c, 8'h3c},
		'{8'ha5, 8'hff, 8'h0f}, '{8'hac, 8'hff, 8'h7f}, '{8'had, 8'h5a, 8'h5a},
		'{8'hb0, 8'hc3, 8'hc3}, '{8'hb1, 8'hff, 8'h0f}};

	always #4 pclk = ~pclk;

	gpx_gpio i_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .pad_in(pad_in), .pad(pad), .periph(periph), .func(func),
		.reset_pin_option(rst_opt), .osc_option(osc), .debug_mode(dbg));

	gpx_pins_model i_pins (.oe(pad.oe), .out(pad.out), .pull_up(pad.pull_up), .ext(ext), .level(pad_in));

	// ---------------------------------------------------------------
	// Tasks
	// ---------------------------------------------------------------
	task automatic apb(input logic wr, input logic [7:0] idx, input logic [7:0] wd);
		@(posedge pclk);
		psel   <= 1'b1;
		pwrite <= wr;
		paddr  <= {2'b00, idx, 2'b00};
		pwdata <= {24'h0, wd};
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
		end while (pready !== 1'b1);
		rd = prdata;
		slv = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
	endtask : apb

	// Option, pad and pin-level stages each take one edge
	task automatic settle();
		repeat (3) @(posedge pclk);
		#1;
	endtask : settle

	task automatic stop_test();
		$display("checks %0d errors %0d", tests_run, err_count);
		if (err_count == 0 && tests_run > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask : stop_test

	initial begin
		#100000;
		err_count++;
		stop_test();
	end

	// ---------------------------------------------------------------
	// Main sequence
	// ---------------------------------------------------------------
	initial begin
		repeat (4) @(posedge pclk);
		presetn <= 1'b1;
		foreach (rows[i]) begin
			apb(1'b0, rows[i].idx, 8'h00);
			`CHK(rd, 32'h0)
		end
		foreach (rows[i]) begin
			apb(1'b1, rows[i].idx, rows[i].wd);
			apb(1'b0, rows[i].idx, 8'h00);
			`CHK(rd, {24'h0, rows[i].exp})
		end
		settle();
		`CHK(pad.oe, {4'hf, 8'h3c, 8'ha5, 7'h7f})
		`CHK(pad.pull_up, {4'h0, 8'hc3, 8'h5a, 7'h00})
		apb(1'b0, 8'hd5, 8'h00);
		`CHK(rd, 32'h5a)
		for (int n = 0; n < 13; n++) begin
			apb(1'b1, 8'hc2, 8'h90 | 8'(n));
			settle();
			exp = (n < 12) ? (27'h1 << (15 + n)) : 27'h0;
			`CHK(pad.analog, exp)
			`CHK(pad.oe & exp, 27'h0)
		end
		apb(1'b1, 8'hc2, 8'h10);
		settle();
		`CHK(pad.analog, 27'h0)
		apb(1'b1, 8'hd0, 8'h01);
		apb(1'b1, 8'hc1, 8'h0d);
		periph.uart_transmit_pin <= 1'b1;
		settle();
		`CHK(func.ext_irq0_input, 1'b1)
		`CHK({pad.out[3], pad.oe[3:2]}, 3'b110)
		apb(1'b1, 8'hc1, 8'h00);
		settle();
		`CHK(func.ext_irq0_input, 1'b0)
		`CHK(pad.oe[3:2], 2'b11)
		apb(1'b1, 8'hc0, 8'h10);
		apb(1'b1, 8'hc3, 8'h07);
		periph.pwm <= 3'b101;
		settle();
		`CHK(pad.out[26:24], 3'b101)
		apb(1'b1, 8'hc0, 8'h11);
		apb(1'b1, 8'hc1, 8'h30);
		periph.serial_data_out <= 1'b1;
		ext[12] <= 1'b1;
		settle();
		`CHK(func.timer_clock, 4'h1)
		`CHK({func.sda_in, func.scl_in, pad.oe[10:9]}, 4'b0100)
		`CHK({pad.oe[14:11], pad.out[11]}, 5'b00011)
		`CHK(func.serial_data_in, 1'b1)
		@(posedge pclk);
		osc     <= GPX_OSC_XTAL;
		dbg     <= 1'b1;
		rst_opt <= 1'b1;
		ext[7]  <= 1'b1;
		settle();
		`CHK(pad.analog[6:5], 2'b11)
		`CHK(func.debug_clock_pin, 1'b1)
		`CHK({pad.oe[4], func.ext_reset_n}, 2'b01)
		@(posedge pclk);
		osc <= GPX_OSC_RC;
		settle();
		`CHK(pad.analog[6:5], 2'b10)
		apb(1'b1, 8'h10, 8'hff);
		`CHK(slv, 1'b1)
		@(posedge pclk);
		presetn <= 1'b0;
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		apb(1'b0, 8'ha0, 8'h00);
		`CHK(rd, 32'h0)
		stop_test();
	end
endmodule : testbench
`default_nettype wire
